// [hw/dinit_pkg.sv]
package dinit_pkg;
  // timing, as printed, and derived cycle counts at the 100 MHz system clock
  localparam int CLK_MHZ = 100;
  localparam int POWER_WAIT_US = 10000;
  localparam int RESET_LOW_US = 200;
  localparam int RESET_WAIT_US = 200;
  localparam int POWER_WAIT_CYC = POWER_WAIT_US * CLK_MHZ;
  localparam int RESET_LOW_CYC = RESET_LOW_US * CLK_MHZ;
  localparam int RESET_WAIT_CYC = RESET_WAIT_US * CLK_MHZ;
  // serial clock divider: half period in system cycles
  localparam int SCLK_HALF_CYC = 10;
  // image plane size in bytes
  localparam int PLANE_BYTES = 81600;
  // command opcodes
  localparam logic [7:0] OP_DRIVER_OUT = 8'h01;
  localparam logic [7:0] OP_DEEP_SLEEP = 8'h10;
  localparam logic [7:0] OP_ENTRY_MODE = 8'h11;
  localparam logic [7:0] OP_SW_RESET = 8'h12;
  localparam logic [7:0] OP_TEMP_SEL = 8'h18;
  localparam logic [7:0] OP_ACTIVATE = 8'h20;
  localparam logic [7:0] OP_UPDATE_CTL = 8'h22;
  localparam logic [7:0] OP_WRITE_BW = 8'h24;
  localparam logic [7:0] OP_WRITE_RED = 8'h26;
  localparam logic [7:0] OP_BOOSTER = 8'h0C;
  localparam logic [7:0] OP_BORDER = 8'h3C;
  localparam logic [7:0] OP_WIN_X = 8'h44;
  localparam logic [7:0] OP_WIN_Y = 8'h45;
  localparam logic [7:0] OP_CNT_X = 8'h4E;
  localparam logic [7:0] OP_CNT_Y = 8'h4F;
  // script entry: data byte, dc bit, busy-wait flag, stream flag
  localparam int SCRIPT_LEN = 53;
  localparam int SCRIPT_AW = 6;
  // script stage indexes (entries where each stage starts)
  localparam logic [SCRIPT_AW-1:0] IDX_SWRESET = 6'h00;
  localparam logic [SCRIPT_AW-1:0] IDX_INIT = 6'h01;
  localparam logic [SCRIPT_AW-1:0] IDX_BW = 6'h1F;
  localparam logic [SCRIPT_AW-1:0] IDX_RED = 6'h26;
  localparam logic [SCRIPT_AW-1:0] IDX_UPDATE = 6'h2D;
  localparam logic [SCRIPT_AW-1:0] IDX_SLEEP = 6'h30;
  localparam logic [SCRIPT_AW-1:0] IDX_END = 6'h32;
  // script entry fields
  localparam int ENT_DC = 8;
  localparam int ENT_WAIT = 9;
  localparam int ENT_STREAM = 10;

  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_PWR = 8'h02,
    ST_RST_LO = 8'h04,
    ST_RST_WAIT = 8'h08,
    ST_FETCH = 8'h10,
    ST_SEND = 8'h20,
    ST_BUSY = 8'h40,
    ST_STREAM = 8'h80
  } dinit_state_type;
endpackage : dinit_pkg

// [hw/dinit_serial.sv]
`timescale 1ns/10ps
// byte shifter: mode 0, msb first, chip select framed per byte
module dinit_serial (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic start,
  input wire logic [7:0] byte_in,
  input wire logic dc_in,
  output logic done,
  output logic sclk,
  output logic mosi,
  output logic cs_n,
  output logic dc
);
  import dinit_pkg::*;
  logic [4:0] div_q;
  logic tick;
  logic [7:0] sh_q;
  logic [4:0] ph_q;
  logic act_q;

  // one-cycle enable every half serial period
  assign tick = (div_q == 5'(SCLK_HALF_CYC - 1));
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      div_q <= 5'h00;
    end else if (!act_q || tick) begin
      div_q <= 5'h00;
    end else begin
      div_q <= div_q + 5'h01;
    end
  end

  // phase 0..15 clocks bits, 16 releases chip select
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      act_q <= 1'b0;
      ph_q <= 5'h00;
      sh_q <= 8'h00;
      sclk <= 1'b0;
      mosi <= 1'b0;
      cs_n <= 1'b1;
      dc <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && !act_q) begin
        act_q <= 1'b1;
        ph_q <= 5'h00;
        sh_q <= byte_in;
        mosi <= byte_in[7];
        dc <= dc_in;
        cs_n <= 1'b0;
      end else if (act_q && tick) begin
        ph_q <= ph_q + 5'h01;
        if (ph_q == 5'h10) begin
          act_q <= 1'b0;
          cs_n <= 1'b1; // release gap is one half period
          done <= 1'b1;
        end else if (!ph_q[0]) begin
          sclk <= 1'b1; // device samples on rising edge
        end else begin
          sclk <= 1'b0;
          sh_q <= {sh_q[6:0], 1'b0};
          mosi <= sh_q[6];
        end
      end
    end
  end
endmodule : dinit_serial

// [hw/dinit_host.sv]
`timescale 1ns/10ps
module dinit_host #(
  parameter int POWER_WAIT = dinit_pkg::POWER_WAIT_CYC,
  parameter int RESET_LOW = dinit_pkg::RESET_LOW_CYC,
  parameter int RESET_WAIT = dinit_pkg::RESET_WAIT_CYC,
  parameter int PLANE_LEN = dinit_pkg::PLANE_BYTES
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic go,
  input wire logic [7:0] pixel_data,
  input wire logic pixel_valid,
  input wire logic busy_pin,
  output logic pixel_ready,
  output logic pixel_plane,
  output logic seq_active,
  output logic seq_done,
  output logic hardware_reset_pin,
  output logic sclk,
  output logic mosi,
  output logic cs_n,
  output logic dc
);
  import dinit_pkg::*;

  // script word: {stream, wait busy after, dc, byte}
  function automatic logic [10:0] script(input logic [SCRIPT_AW-1:0] i);
    case (i)
      6'h00: script = {3'b010, OP_SW_RESET};
      6'h01: script = {3'b000, OP_BOOSTER};
      6'h02: script = {3'b001, 8'hAE};
      6'h03: script = {3'b001, 8'hC7};
      6'h04: script = {3'b001, 8'hC3};
      6'h05: script = {3'b001, 8'hC0};
      6'h06: script = {3'b001, 8'h80};
      6'h07: script = {3'b000, OP_DRIVER_OUT};
      6'h08: script = {3'b001, 8'hA7};
      6'h09: script = {3'b001, 8'h02};
      6'h0A: script = {3'b001, 8'h00};
      6'h0B: script = {3'b000, OP_ENTRY_MODE};
      6'h0C: script = {3'b001, 8'h01};
      6'h0D: script = {3'b000, OP_WIN_X};
      6'h0E: script = {3'b001, 8'h00};
      6'h0F: script = {3'b001, 8'h00};
      6'h10: script = {3'b001, 8'hBF};
      6'h11: script = {3'b001, 8'h03};
      6'h12: script = {3'b000, OP_WIN_Y};
      6'h13: script = {3'b001, 8'hA7};
      6'h14: script = {3'b001, 8'h02};
      6'h15: script = {3'b001, 8'h00};
      6'h16: script = {3'b001, 8'h00};
      6'h17: script = {3'b000, OP_BORDER};
      6'h18: script = {3'b001, 8'h01};
      6'h19: script = {3'b000, OP_TEMP_SEL};
      6'h1A: script = {3'b001, 8'h80};
      6'h1B: script = {3'b000, OP_UPDATE_CTL};
      6'h1C: script = {3'b001, 8'hB1};
      6'h1D: script = {3'b000, OP_ACTIVATE};
      6'h1E: script = {3'b010, 8'h00}; // pure busy wait, nothing sent
      6'h1F: script = {3'b000, OP_CNT_X};
      6'h20: script = {3'b001, 8'h00};
      6'h21: script = {3'b001, 8'h00};
      6'h22: script = {3'b000, OP_CNT_Y};
      6'h23: script = {3'b001, 8'hA7};
      6'h24: script = {3'b001, 8'h02};
      6'h25: script = {3'b100, OP_WRITE_BW};
      6'h26: script = {3'b000, OP_CNT_X};
      6'h27: script = {3'b001, 8'h00};
      6'h28: script = {3'b001, 8'h00};
      6'h29: script = {3'b000, OP_CNT_Y};
      6'h2A: script = {3'b001, 8'hA7};
      6'h2B: script = {3'b001, 8'h02};
      6'h2C: script = {3'b100, OP_WRITE_RED};
      6'h2D: script = {3'b000, OP_UPDATE_CTL};
      6'h2E: script = {3'b001, 8'hC7};
      6'h2F: script = {3'b010, OP_ACTIVATE};
      6'h30: script = {3'b000, OP_DEEP_SLEEP};
      6'h31: script = {3'b001, 8'h01};
      default: script = 11'h000;
    endcase
  endfunction : script

  dinit_state_type st_q;
  logic [SCRIPT_AW-1:0] idx_q;
  logic [23:0] cnt_q;
  logic [16:0] pix_q;
  logic busy_m_q;
  logic busy_s_q;
  logic ser_start;
  logic ser_done;
  logic [7:0] ser_byte;
  logic ser_dc;
  logic [10:0] ent;
  logic skip_send;

  assign ent = script(idx_q);
  // the pure busy-wait entry sends nothing
  assign skip_send = (idx_q == (IDX_BW - 6'h01));
  assign ser_start = (st_q == ST_SEND) || (st_q == ST_STREAM && pixel_valid && pixel_ready);
  assign ser_byte = (st_q == ST_STREAM) ? pixel_data : ent[7:0];
  assign ser_dc = (st_q == ST_STREAM) ? 1'b1 : ent[ENT_DC];

  // busy comes from the panel, so synchronise it first
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      busy_m_q <= 1'b1;
      busy_s_q <= 1'b1;
    end else begin
      busy_m_q <= busy_pin;
      busy_s_q <= busy_m_q;
    end
  end

  // sequencer: power wait, pin reset, script with busy waits and streams
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      st_q <= ST_IDLE;
      idx_q <= IDX_SWRESET;
      cnt_q <= 24'h000000;
      pix_q <= 17'h00000;
      hardware_reset_pin <= 1'b1;
      pixel_ready <= 1'b0;
      pixel_plane <= 1'b0;
      seq_active <= 1'b0;
      seq_done <= 1'b0;
    end else begin
      seq_done <= 1'b0;
      case (st_q)
        ST_IDLE: begin
          if (go) begin
            st_q <= ST_PWR;
            cnt_q <= 24'h000000;
            seq_active <= 1'b1;
          end
        end
        ST_PWR: begin
          cnt_q <= cnt_q + 24'h000001;
          if (cnt_q == 24'(POWER_WAIT - 1)) begin
            st_q <= ST_RST_LO;
            cnt_q <= 24'h000000;
            hardware_reset_pin <= 1'b0;
          end
        end
        ST_RST_LO: begin
          cnt_q <= cnt_q + 24'h000001;
          if (cnt_q == 24'(RESET_LOW - 1)) begin
            st_q <= ST_RST_WAIT;
            cnt_q <= 24'h000000;
            hardware_reset_pin <= 1'b1;
          end
        end
        ST_RST_WAIT: begin
          cnt_q <= cnt_q + 24'h000001;
          if (cnt_q == 24'(RESET_WAIT - 1)) begin
            st_q <= ST_BUSY; // wait busy low before soft reset
            idx_q <= IDX_SWRESET;
          end
        end
        ST_FETCH: begin
          if (idx_q == IDX_END) begin
            st_q <= ST_IDLE;
            seq_active <= 1'b0;
            seq_done <= 1'b1;
          end else if (skip_send) begin
            st_q <= ST_BUSY;
            cnt_q <= 24'hFFFFFF; // no byte to wait for, so go straight to the busy check of this entry
          end else begin
            st_q <= ST_SEND;
          end
        end
        ST_SEND: begin
          st_q <= ST_BUSY;
          cnt_q <= 24'h000000; // keeps the first-busy-low branch from firing again mid-byte
        end
        ST_BUSY: begin
          // wait for the byte to finish, then for busy low where marked
          if (ser_done || cnt_q == 24'hFFFFFF) begin
            cnt_q <= 24'hFFFFFF;
            if (ent[ENT_STREAM] && cnt_q != 24'hFFFFFF) begin
              st_q <= ST_STREAM;
              pix_q <= 17'h00000;
              pixel_plane <= (idx_q == IDX_UPDATE - 6'h01);
              pixel_ready <= 1'b1;
            end else if (!ent[ENT_WAIT] || !busy_s_q) begin
              st_q <= ST_FETCH;
              idx_q <= idx_q + 6'h01;
              cnt_q <= 24'h000000;
            end
          end else if (idx_q == IDX_SWRESET && st_q == ST_BUSY && !busy_s_q && cnt_q != 24'h000000) begin
            st_q <= ST_SEND; // first busy low after pin reset
          end
        end
        ST_STREAM: begin
          if (ser_start) begin
            pixel_ready <= 1'b0; // one byte in flight
          end
          if (ser_done) begin
            pix_q <= pix_q + 17'h00001;
            if (pix_q == 17'(PLANE_LEN - 1)) begin
              st_q <= ST_FETCH;
              idx_q <= idx_q + 6'h01;
              cnt_q <= 24'h000000;
            end else begin
              pixel_ready <= 1'b1;
            end
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  dinit_serial u_serial (
    .clk_sys(clk_sys),
    .reset(reset),
    .start(ser_start),
    .byte_in(ser_byte),
    .dc_in(ser_dc),
    .done(ser_done),
    .sclk(sclk),
    .mosi(mosi),
    .cs_n(cs_n),
    .dc(dc)
  );
endmodule : dinit_host

// [tb/dinit_host_asserts.sv]
`timescale 1ns/10ps
module dinit_host_asserts #(
  parameter int POWER_WAIT = 50,
  parameter int RESET_LOW = 20,
  parameter int RESET_WAIT = 20
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic busy_pin,
  input wire logic pixel_valid,
  input wire logic pixel_ready,
  input wire logic pixel_plane,
  input wire logic seq_active,
  input wire logic seq_done,
  input wire logic hardware_reset_pin,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic dc
);
  int lo_q, act_q, rw_q, bit_q;
  logic sclk_q;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // cycle counters for the long waits; a repetition would unroll too far
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      lo_q <= 0;
      act_q <= 0;
      rw_q <= 0;
    end else begin
      lo_q <= hardware_reset_pin ? 0 : lo_q + 1;
      act_q <= seq_active ? act_q + 1 : 0;
      rw_q <= !hardware_reset_pin ? 0 : (rw_q < 1000000 ? rw_q + 1 : rw_q); // saturates
    end
  end
  // serial clock rises seen since the frame opened
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sclk_q <= 1'b0;
      bit_q <= 0;
    end else begin
      sclk_q <= sclk;
      bit_q <= cs_n ? 0 : bit_q + int'(sclk && !sclk_q);
    end
  end
  a_reset_low_time: assert property ($rose(hardware_reset_pin) |-> lo_q == RESET_LOW)
    else $error("reset pin low time wrong");
  a_power_wait: assert property ($fell(hardware_reset_pin) |-> act_q inside {[POWER_WAIT-1:POWER_WAIT+2]})
    else $error("power wait wrong");
  a_reset_settle: assert property ($fell(cs_n) |-> rw_q >= RESET_WAIT)
    else $error("byte too soon after pin reset");
  a_busy_respect: assert property ($fell(cs_n) |-> !busy_pin && !$past(busy_pin, 2))
    else $error("byte started while busy");
  a_byte_whole: assert property ($rose(cs_n) |-> bit_q == 8)
    else $error("frame not eight bits");
  a_dc_steady: assert property (!cs_n && !$fell(cs_n) |-> $stable(dc))
    else $error("dc moved inside frame");
  a_ready_drop: assert property (pixel_valid && pixel_ready |=> !pixel_ready)
    else $error("ready held after take");
  a_done_pulse: assert property (seq_done |=> !seq_done ##[0:1] !seq_active)
    else $error("done not a single pulse");
  cover property ($rose(hardware_reset_pin));
  cover property (pixel_valid && pixel_ready && pixel_plane);
  cover property (seq_done);
endmodule : dinit_host_asserts

// [tb/dinit_panel_model.sv]
`timescale 1ns/10ps
// panel stand-in: takes framed bytes on sclk rise and drives busy
module dinit_panel_model (
  input wire logic clk_sys,
  input wire logic hardware_reset_pin,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic cs_n,
  input wire logic dc,
  output logic busy_pin
);
  logic [8:0] got[$];
  logic [7:0] mem[2][16];
  logic [7:0] sh, op;
  int nb, early, addr;
  int busy_left = 25;
  initial busy_pin <= 1'b1;
  // each frame restarts the bit count
  always @(negedge cs_n) nb = 0;
  // msb first; busy rises at the last bit of a 12 or 20 opcode or a 10 parameter byte so the host cannot slip past it
  always @(posedge sclk) begin
    if (!cs_n) begin
      sh = {sh[6:0], mosi};
      nb = nb + 1;
      if (nb == 8) begin
        got.push_back({dc, sh});
        if (busy_pin) early = early + 1;
        if (!dc) op = sh;
        if (!dc && (sh == 8'h12 || sh == 8'h20)) busy_left = (sh == 8'h12) ? 30 : 90;
        if (!dc && (sh == 8'h4E || sh == 8'h4F)) addr = 0;
        if (dc && op[7:2] == 6'h09) mem[op[1]][addr[3:0]] = sh;
        if (dc && op[7:2] == 6'h09) addr = addr + 1;
        if (dc && op == 8'h10) busy_left = 1000000;
        busy_pin <= busy_left != 0; // scheduled after the clock process, so it wins
      end
    end
  end
  // pin reset restarts the power-up work; busy falls when the count ends
  always @(posedge clk_sys) begin
    if (!hardware_reset_pin) busy_left = 25;
    else if (busy_left != 0) busy_left = busy_left - 1;
    busy_pin <= busy_left != 0;
  end
endmodule : dinit_panel_model

// [tb/dinit_host_tb.sv]
`timescale 1ns/10ps
module dinit_host_tb;
  localparam int PL = 4;
  logic clk_sys, reset, go, pixel_valid, busy_pin, pixel_ready, pixel_plane;
  logic seq_active, seq_done, hardware_reset_pin, sclk, mosi, cs_n, dc;
  logic [7:0] pixel_data;
  logic [8:0] exp_q[$];
  int failures, num_checks, taken;
  dinit_host #(.POWER_WAIT(50), .RESET_LOW(20), .RESET_WAIT(20), .PLANE_LEN(PL)) DUT (
    .clk_sys, .reset, .go, .pixel_data, .pixel_valid, .busy_pin, .pixel_ready, .pixel_plane,
    .seq_active, .seq_done, .hardware_reset_pin, .sclk, .mosi, .cs_n, .dc);
  dinit_panel_model P (.clk_sys, .hardware_reset_pin, .sclk, .mosi, .cs_n, .dc, .busy_pin);
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", what, e, g);
      failures++;
    end
  endtask : chk
  task automatic report_and_stop;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  // opcode then n parameter bytes, first byte at the top of the low n bytes of p
  task automatic cmd(input logic [7:0] o, input int n, input logic [39:0] p);
    exp_q.push_back({1'b0, o});
    for (int i = n - 1; i >= 0; i--) exp_q.push_back({1'b1, p[8*i +: 8]});
  endtask : cmd
  task automatic plan_run;
    exp_q = {};
    cmd(8'h12, 0, 40'h0);
    cmd(8'h0C, 5, 40'hAEC7C3C080);
    cmd(8'h01, 3, 40'hA70200);
    cmd(8'h11, 1, 40'h01);
    cmd(8'h44, 4, 40'h0000BF03);
    cmd(8'h45, 4, 40'hA7020000);
    cmd(8'h3C, 1, 40'h01);
    cmd(8'h18, 1, 40'h80);
    cmd(8'h22, 1, 40'hB1);
    cmd(8'h20, 0, 40'h0);
    for (int pl = 0; pl < 2; pl++) begin
      cmd(8'h4E, 2, 40'h0);
      cmd(8'h4F, 2, 40'hA702);
      cmd(pl ? 8'h26 : 8'h24, 0, 40'h0);
      for (int k = 0; k < PL; k++) exp_q.push_back({1'b1, 8'h5A + 8'(pl * PL + k)});
    end
    cmd(8'h22, 1, 40'hC7);
    cmd(8'h20, 0, 40'h0);
    cmd(8'h10, 1, 40'h01);
  endtask : plan_run
  // bounded wait for the end pulse, then compare all the panel saw
  task automatic finish_run(input string name);
    int n;
    n = 0;
    while (seq_done !== 1'b1 && n < 40000) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (n >= 40000) begin
      failures++;
      report_and_stop();
    end
    chk("byte count", exp_q.size(), P.got.size());
    foreach (exp_q[i]) chk("frame byte", exp_q[i], P.got[i]);
    chk("busy overrun", 0, P.early);
    chk("bytes taken", 2 * PL, taken);
    for (int k = 0; k < 2 * PL; k++) chk("plane memory", 8'h5A + 8'(k), P.mem[k / PL][k % PL]);
    $display("test %s done", name);
  endtask : finish_run
  task automatic start;
    @(posedge clk_sys);
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
  endtask : start
  // image source always offers a byte; extra takes would show in the count
  always @(posedge clk_sys) begin
    if (pixel_valid && pixel_ready) begin
      chk("plane select", taken >= PL, pixel_plane);
      taken <= taken + 1;
      pixel_data <= 8'h5A + 8'(taken + 1);
    end
  end
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // full run with a refused restart, then a reset in mid-run and a rerun
  initial begin
    reset = 1'b1;
    go = 1'b0;
    pixel_valid = 1'b0;
    pixel_data = 8'h5A;
    failures = 0;
    num_checks = 0;
    taken = 0;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    plan_run();
    pixel_valid <= 1'b1;
    start();
    repeat (400) @(posedge clk_sys);
    start();
    finish_run("full sequence");
    start();
    repeat (3000) @(posedge clk_sys);
    reset <= 1'b1;
    @(posedge clk_sys);
    #1;
    chk("reset pin idle", 1, hardware_reset_pin);
    chk("select idle", 1, cs_n);
    chk("active idle", 0, seq_active);
    P.got.delete();
    taken = 0;
    @(posedge clk_sys);
    reset <= 1'b0;
    pixel_data <= 8'h5A;
    start();
    finish_run("reset in mid-run");
    report_and_stop();
  end
endmodule : dinit_host_tb
bind dinit_host dinit_host_asserts #(.POWER_WAIT(POWER_WAIT), .RESET_LOW(RESET_LOW), .RESET_WAIT(RESET_WAIT)) u_chk (
  .clk_sys, .reset, .busy_pin, .pixel_valid, .pixel_ready, .pixel_plane, .seq_active, .seq_done,
  .hardware_reset_pin, .sclk, .cs_n, .dc);
